// ### src/rre_pkg.sv
// Purpose: Shared constants and types for the return and rotate executor
// Assumes: 8-bit data path, 15-bit program counter
// Notes:   Cycle counts are whole instruction cycles of core_clk_i
package rre_pkg;
    localparam int DATA_W_DEF  = 8;
    localparam int PC_W_DEF    = 15;
    localparam int ADDR_W      = 7;
    // Global enable position inside the interrupt control register
    localparam int GLB_EN_BIT  = 7;
    localparam int RET_CYCLES  = 2;
    localparam int ROT_CYCLES  = 1;
    localparam logic DEST_W    = 1'h0;
    localparam logic DEST_F    = 1'h1;
    localparam logic DIR_LEFT  = 1'h0;
    localparam logic DIR_RIGHT = 1'h1;

    typedef enum logic [2:0] {
        RRE_OP_NONE     = 3'h0,
        RRE_OP_RET_IRQ  = 3'h1,
        RRE_OP_RETURN   = 3'h2,
        RRE_OP_RET_LIT  = 3'h3,
        RRE_OP_ROT_LEFT = 3'h4,
        RRE_OP_ROT_RGHT = 3'h5
    } rre_op_t;

    typedef enum logic [0:0] {
        RRE_ST_IDLE   = 1'h0,
        RRE_ST_SECOND = 1'h1
    } rre_state_t;
endpackage

// ### src/rre_rotate.sv
// Purpose: One-bit rotate through carry, either direction
// Assumes: Purely combinational, used inside one cycle
// Notes:   Width is a parameter; carry is the extra ring bit
`timescale 1ns/1ps
module rre_rotate #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             carry_i,
    input  wire logic             dir_i,
    output logic      [WIDTH-1:0] result_o,
    output logic                  carry_o
);
    import rre_pkg::*;

    initial begin
        if (WIDTH < 2) begin
            $error("rre_rotate: WIDTH must be at least 2");
        end
    end

    always_comb begin
        if (dir_i == DIR_LEFT) begin
            result_o = {data_i[WIDTH-2:0], carry_i};
            carry_o  = data_i[WIDTH-1];
        end else begin
            result_o = {carry_i, data_i[WIDTH-1:1]};
            carry_o  = data_i[0];
        end
    end
endmodule

// ### src/rre_exec.sv
// Purpose: Executes return and rotate-through-carry operations
// Assumes: Decoded op arrives with operands valid in the same cycle
// Notes:   Ops offered while busy are ignored; fetch must hold off
`timescale 1ns/1ps
module rre_exec #(
    parameter int DATA_W = rre_pkg::DATA_W_DEF,
    parameter int PC_W   = rre_pkg::PC_W_DEF
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   op_valid_i,
    input  wire rre_pkg::rre_op_t       op_code_i,
    input  wire logic [DATA_W-1:0]      literal_i,
    input  wire logic                   dest_i,
    input  wire logic [rre_pkg::ADDR_W-1:0] file_addr_i,
    input  wire logic [DATA_W-1:0]      file_data_i,
    input  wire logic                   carry_i,
    input  wire logic [PC_W-1:0]        stack_top_i,
    input  wire logic [DATA_W-1:0]      irq_ctrl_i,
    output logic                        busy_o,
    output logic                        done_o,
    output logic                        stack_pop_o,
    output logic                        pc_load_o,
    output logic [PC_W-1:0]             pc_value_o,
    output logic                        w_we_o,
    output logic                        file_we_o,
    output logic [rre_pkg::ADDR_W-1:0]  file_addr_o,
    output logic [DATA_W-1:0]           result_o,
    output logic                        carry_we_o,
    output logic                        carry_o,
    output logic                        irq_ctrl_we_o,
    output logic [DATA_W-1:0]           irq_ctrl_wdata_o
);
    import rre_pkg::*;

    initial begin
        if (DATA_W <= GLB_EN_BIT) begin
            $error("rre_exec: DATA_W too narrow for global enable bit");
        end
        if (PC_W < 1) begin
            $error("rre_exec: PC_W must be positive");
        end
    end

    function automatic logic is_ret(input rre_op_t op);
        is_ret = (op == RRE_OP_RET_IRQ) || (op == RRE_OP_RETURN) || (op == RRE_OP_RET_LIT);
    endfunction

    function automatic logic is_rot(input rre_op_t op);
        is_rot = (op == RRE_OP_ROT_LEFT) || (op == RRE_OP_ROT_RGHT);
    endfunction

    rre_state_t         state_ff;
    rre_state_t         nxt_state;
    logic               busy_ff;
    logic               done_ff;
    logic               pop_ff;
    logic               pc_load_ff;
    logic [PC_W-1:0]    pc_value_ff;
    logic               w_we_ff;
    logic               file_we_ff;
    logic [ADDR_W-1:0]  file_addr_ff;
    logic [DATA_W-1:0]  result_ff;
    logic               carry_we_ff;
    logic               carry_ff;
    logic               irq_we_ff;
    logic [DATA_W-1:0]  irq_wdata_ff;
    logic               take;
    logic [DATA_W-1:0]  rot_result;
    logic               rot_carry;
    logic               rot_dir;
    logic               fwd_file;
    logic [DATA_W-1:0]  rot_data;
    logic               rot_cin;

    // Only one op in flight; the second return cycle refuses new work
    assign take    = op_valid_i && (state_ff == RRE_ST_IDLE);
    assign rot_dir = (op_code_i == RRE_OP_ROT_RGHT) ? DIR_RIGHT : DIR_LEFT;

    // Writes land at the far side one edge late; a chained rotate must see them now
    assign fwd_file = file_we_ff && (file_addr_ff == file_addr_i);
    assign rot_data = fwd_file ? result_ff : file_data_i;
    assign rot_cin  = carry_we_ff ? carry_ff : carry_i;

    rre_rotate #(
        .WIDTH (DATA_W)
    ) u_rotate (
        .data_i   (rot_data),
        .carry_i  (rot_cin),
        .dir_i    (rot_dir),
        .result_o (rot_result),
        .carry_o  (rot_carry)
    );

    // Returns hold a second cycle for the pipeline refill
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RRE_ST_IDLE: begin
                if (take && is_ret(op_code_i)) begin
                    nxt_state = RRE_ST_SECOND;
                end
            end
            RRE_ST_SECOND: begin
                nxt_state = RRE_ST_IDLE;
            end
            default: begin
                nxt_state = RRE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= RRE_ST_IDLE;
            busy_ff  <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state == RRE_ST_SECOND);
        end
    end

    // Done marks the last cycle of any op: second for returns, first for rotates
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            done_ff <= 1'h0;
        end else begin
            done_ff <= (state_ff == RRE_ST_SECOND) || (take && is_rot(op_code_i));
        end
    end

    // Stack pop and PC reload issued together in the first return cycle
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pop_ff      <= 1'h0;
            pc_load_ff  <= 1'h0;
            pc_value_ff <= '0;
        end else begin
            pop_ff     <= take && is_ret(op_code_i);
            pc_load_ff <= take && is_ret(op_code_i);
            if (take && is_ret(op_code_i)) begin
                pc_value_ff <= stack_top_i;
            end
        end
    end

    // Accumulator and file writes share one result path
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            w_we_ff      <= 1'h0;
            file_we_ff   <= 1'h0;
            file_addr_ff <= '0;
            result_ff    <= '0;
        end else begin
            w_we_ff    <= 1'h0;
            file_we_ff <= 1'h0;
            if (take && op_code_i == RRE_OP_RET_LIT) begin
                w_we_ff   <= 1'h1;
                result_ff <= literal_i;
            end else if (take && is_rot(op_code_i)) begin
                result_ff    <= rot_result;
                file_addr_ff <= file_addr_i;
                w_we_ff      <= (dest_i == DEST_W);
                file_we_ff   <= (dest_i == DEST_F);
            end
        end
    end

    // Carry is the only status touched; Z and DC stay with the core
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            carry_we_ff <= 1'h0;
            carry_ff    <= 1'h0;
        end else begin
            carry_we_ff <= take && is_rot(op_code_i);
            if (take && is_rot(op_code_i)) begin
                carry_ff <= rot_carry;
            end
        end
    end

    // Read-modify-write keeps the other interrupt control bits intact
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_we_ff    <= 1'h0;
            irq_wdata_ff <= '0;
        end else begin
            irq_we_ff <= take && op_code_i == RRE_OP_RET_IRQ;
            if (take && op_code_i == RRE_OP_RET_IRQ) begin
                irq_wdata_ff             <= irq_ctrl_i;
                irq_wdata_ff[GLB_EN_BIT] <= 1'h1;
            end
        end
    end

    assign busy_o           = busy_ff;
    assign done_o           = done_ff;
    assign stack_pop_o      = pop_ff;
    assign pc_load_o        = pc_load_ff;
    assign pc_value_o       = pc_value_ff;
    assign w_we_o           = w_we_ff;
    assign file_we_o        = file_we_ff;
    assign file_addr_o      = file_addr_ff;
    assign result_o         = result_ff;
    assign carry_we_o       = carry_we_ff;
    assign carry_o          = carry_ff;
    assign irq_ctrl_we_o    = irq_we_ff;
    assign irq_ctrl_wdata_o = irq_wdata_ff;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_ret_pop_pc: assert property (take && is_ret(op_code_i) |=>
        stack_pop_o && pc_load_o && pc_value_o == $past(stack_top_i))
        else $error("return did not pop stack into PC");
    chk_ret_two_cyc: assert property (take && is_ret(op_code_i) |=>
        busy_o && !done_o ##1 done_o && !busy_o && !stack_pop_o)
        else $error("return did not take two cycles");
    chk_irq_ret_enable: assert property (take && op_code_i == RRE_OP_RET_IRQ |=>
        irq_ctrl_we_o && irq_ctrl_wdata_o[GLB_EN_BIT])
        else $error("interrupt return did not set global enable");
    chk_return_enable: assert property (take && op_code_i != RRE_OP_RET_IRQ |=>
        !irq_ctrl_we_o)
        else $error("global enable touched by non-interrupt op");
    chk_lit_ret_w: assert property (take && op_code_i == RRE_OP_RET_LIT |=>
        w_we_o && !file_we_o && result_o == $past(literal_i))
        else $error("literal return did not load accumulator");
    chk_rotl_value: assert property (take && op_code_i == RRE_OP_ROT_LEFT |=>
        result_o == {$past(rot_data[DATA_W-2:0]), $past(rot_cin)}
        && carry_o == $past(rot_data[DATA_W-1]) && carry_we_o && done_o)
        else $error("rotate left result or carry wrong");
    chk_rotl_dest: assert property (take && op_code_i == RRE_OP_ROT_LEFT |=>
        file_we_o == $past(dest_i) && w_we_o == !$past(dest_i))
        else $error("rotate left destination wrong");
    chk_rotr_value: assert property (take && op_code_i == RRE_OP_ROT_RGHT |=>
        result_o == {$past(rot_cin), $past(rot_data[DATA_W-1:1])}
        && carry_o == $past(rot_data[0]) && carry_we_o)
        else $error("rotate right result or carry wrong");
    chk_rotr_dest: assert property (take && op_code_i == RRE_OP_ROT_RGHT |=>
        file_we_o == $past(dest_i) && w_we_o == !$past(dest_i)
        && file_addr_o == $past(file_addr_i))
        else $error("rotate right destination wrong");
    chk_rotr_one: assert property (take && op_code_i == RRE_OP_ROT_RGHT |=>
        done_o && !busy_o ##1 (!done_o || carry_we_o))
        else $error("rotate right not single cycle");

    cov_irq_ret: cover property (take && op_code_i == RRE_OP_RET_IRQ ##2 done_o);
    cov_lit_ret: cover property (take && op_code_i == RRE_OP_RET_LIT ##2 take);
    cov_rot_chain: cover property (take && is_rot(op_code_i) && carry_we_o);
    cov_rot_file: cover property (take && is_rot(op_code_i) && dest_i ##1 file_we_o);
    cov_busy_drop: cover property (busy_o && op_valid_i);
endmodule

// ### sim/rre_core_model.sv
// Purpose: Far side of the executor: data memory, carry, W, control reg, stack
// Assumes: Bench preloads state between ops by hierarchical write
// Notes:   One-entry stack; a pop exposes a different next entry
`timescale 1ns/1ps
module rre_core_model (
    input  wire logic        core_clk_i,
    input  wire logic [6:0]  rd_addr_i,
    input  wire logic        stack_pop_i,
    input  wire logic        pc_load_i,
    input  wire logic [14:0] pc_value_i,
    input  wire logic        w_we_i,
    input  wire logic        file_we_i,
    input  wire logic [6:0]  file_addr_i,
    input  wire logic [7:0]  result_i,
    input  wire logic        carry_we_i,
    input  wire logic        carry_i,
    input  wire logic        irq_ctrl_we_i,
    input  wire logic [7:0]  irq_ctrl_wdata_i,
    output logic      [7:0]  file_data_o,
    output logic             carry_o,
    output logic      [14:0] stack_top_o,
    output logic      [7:0]  irq_ctrl_o
);
    logic [7:0]  mem [128];
    logic [7:0]  w_ff   = 8'h00;
    logic [14:0] pc_ff  = 15'h0000;
    logic [14:0] stack_ff = 15'h0000;
    logic        carry_ff = 1'b0;
    logic [7:0]  irq_ff = 8'h00;
    assign file_data_o = mem[rd_addr_i];
    assign carry_o     = carry_ff;
    assign stack_top_o = stack_ff;
    assign irq_ctrl_o  = irq_ff;
    always @(posedge core_clk_i) begin
        if (file_we_i) mem[file_addr_i] <= result_i;
        if (w_we_i) w_ff <= result_i;
        if (carry_we_i) carry_ff <= carry_i;
        if (irq_ctrl_we_i) irq_ff <= irq_ctrl_wdata_i;
        if (pc_load_i) pc_ff <= pc_value_i;
        // Stale top must not survive a pop
        if (stack_pop_i) stack_ff <= ~stack_ff;
    end
endmodule

// ### sim/tb_return_rotate_exec.sv
// Purpose: Self-checking bench for the return and rotate executor
// Assumes: Inputs change at the falling edge; one op at a time
// Notes:   Random ops mixed with fixed corner cases, fixed seed
`timescale 1ns/1ps
module tb_return_rotate_exec;
    import rre_pkg::*;
    logic        core_clk_i  = 1'b0;
    logic        reset_n_i   = 1'b0;
    logic        op_valid_i  = 1'b0;
    rre_op_t     op_code_i   = RRE_OP_NONE;
    logic [7:0]  literal_i   = 8'h00;
    logic        dest_i      = 1'b0;
    logic [6:0]  file_addr_i = 7'h00;
    logic [7:0]  file_data_i, irq_ctrl_i, result_o, irq_ctrl_wdata_o;
    logic        carry_i, busy_o, done_o, stack_pop_o, pc_load_o, w_we_o;
    logic        file_we_o, carry_we_o, carry_o, irq_ctrl_we_o;
    logic [14:0] stack_top_i, pc_value_o;
    logic [6:0]  file_addr_o;
    int          fails   = 0;
    int          n_tests = 0;
    int          seed    = 32'hff7528b1;
    int          i;
    // Results of a chained rotate that the model has not stored yet
    logic        fw_c_v  = 1'b0;
    logic        fw_f_v  = 1'b0;
    logic        fw_c    = 1'b0;
    logic [6:0]  fw_a    = 7'h00;
    logic [7:0]  fw_r    = 8'h00;
    wire  [7:0]  pulses = {busy_o, done_o, stack_pop_o, pc_load_o, w_we_o, file_we_o, carry_we_o, irq_ctrl_we_o};
    always #25 core_clk_i = ~core_clk_i;
    rre_exec u_rre_exec (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .literal_i(literal_i), .dest_i(dest_i), .file_addr_i(file_addr_i),
        .file_data_i(file_data_i), .carry_i(carry_i), .stack_top_i(stack_top_i), .irq_ctrl_i(irq_ctrl_i),
        .busy_o(busy_o), .done_o(done_o), .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o),
        .pc_value_o(pc_value_o), .w_we_o(w_we_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
        .result_o(result_o), .carry_we_o(carry_we_o), .carry_o(carry_o), .irq_ctrl_we_o(irq_ctrl_we_o),
        .irq_ctrl_wdata_o(irq_ctrl_wdata_o));
    rre_core_model u_rre_core_model (.core_clk_i(core_clk_i), .rd_addr_i(file_addr_i),
        .stack_pop_i(stack_pop_o), .pc_load_i(pc_load_o), .pc_value_i(pc_value_o), .w_we_i(w_we_o),
        .file_we_i(file_we_o), .file_addr_i(file_addr_o), .result_i(result_o), .carry_we_i(carry_we_o),
        .carry_i(carry_o), .irq_ctrl_we_i(irq_ctrl_we_o), .irq_ctrl_wdata_i(irq_ctrl_wdata_o),
        .file_data_o(file_data_i), .carry_o(carry_i), .stack_top_o(stack_top_i), .irq_ctrl_o(irq_ctrl_i));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [8:0] rot(input rre_op_t op, input logic [7:0] v, input logic c);
        return (op == RRE_OP_ROT_LEFT) ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Called just after a falling edge; nxt keeps valid high for a following op or a poke while busy
    task automatic do_op(input rre_op_t op, input logic [7:0] lit, input logic d, input logic [6:0] a,
                         input logic nxt);
        logic [7:0]  fd, irq;
        logic        c;
        logic [14:0] top_v;
        logic [8:0]  r;
        logic        ret;
        file_addr_i = a;
        op_code_i   = op;
        literal_i   = lit;
        dest_i      = d;
        // Held high across chained ops, never set twice in one step
        if (op_valid_i !== 1'b1) op_valid_i = 1'b1;
        #1;
        fd    = file_data_i;
        c     = carry_i;
        top_v = stack_top_i;
        irq   = irq_ctrl_i;
        if (fw_c_v) c = fw_c;
        if (fw_f_v && fw_a == a) fd = fw_r;
        fw_c_v = 1'b0;
        fw_f_v = 1'b0;
        r   = rot(op, fd, c);
        ret = (op == RRE_OP_RET_IRQ) || (op == RRE_OP_RETURN) || (op == RRE_OP_RET_LIT);
        @(negedge core_clk_i);
        op_valid_i = nxt;
        if (ret) begin
            check("return pulses", pulses,
                  8'hB0 | {4'h0, op == RRE_OP_RET_LIT, 2'h0, op == RRE_OP_RET_IRQ});
            check("pc value", pc_value_o, top_v);
            if (op == RRE_OP_RET_IRQ) check("irq wdata", irq_ctrl_wdata_o, irq | 8'h80);
            if (op == RRE_OP_RET_LIT) check("literal", result_o, lit);
            @(negedge core_clk_i);
            check("return end", pulses, 8'h40);
            if (op == RRE_OP_RET_LIT) check("w after", u_rre_core_model.w_ff, lit);
            check("irq after", u_rre_core_model.irq_ff, (op == RRE_OP_RET_IRQ) ? (irq | 8'h80) : irq);
            if (nxt) begin
                op_valid_i = 1'b0;
                @(negedge core_clk_i);
                check("busy poke", pulses, 8'h00);
            end
        end else begin
            check("rot pulses", pulses, {6'h10 | {4'h0, ~d, d}, 2'h2});
            check("rot result", {carry_o, result_o}, r);
            check("rot addr", file_addr_o, a);
            fw_c_v = nxt;
            fw_c   = r[8];
            fw_f_v = nxt && d;
            fw_a   = a;
            fw_r   = r[7:0];
            if (!nxt) begin
                @(negedge core_clk_i);
                check("rot end", pulses, 8'h00);
            end
        end
    endtask

    initial begin
        rre_op_t op;
        repeat (10) @(negedge core_clk_i);
        check("reset pulses", pulses, 8'h00);
        reset_n_i = 1'b1;
        for (i = 0; i < 128; i++) u_rre_core_model.mem[i] = 8'($random(seed));
        @(negedge core_clk_i);
        u_rre_core_model.mem[5] = 8'hE6;
        do_op(RRE_OP_ROT_LEFT, 8'h00, 1'b1, 7'h05, 1'b1);
        check("walk value", result_o, 8'hCC);
        do_op(RRE_OP_ROT_RGHT, 8'h00, 1'b0, 7'h05, 1'b1);
        check("chain value", result_o, 8'hE6);
        do_op(RRE_OP_ROT_RGHT, 8'h00, 1'b1, 7'h05, 1'b0);
        u_rre_core_model.irq_ff = 8'h00;
        do_op(RRE_OP_RET_IRQ, 8'h00, 1'b0, 7'h00, 1'b1);
        do_op(RRE_OP_RET_LIT, 8'hFF, 1'b0, 7'h7F, 1'b0);
        do_op(RRE_OP_RETURN, 8'h00, 1'b0, 7'h00, 1'b1);
        $display("test corners done");
        for (i = 0; i < 400; i++) begin
            op = rre_op_t'(3'h1 + 3'($unsigned($random(seed)) % 5));
            u_rre_core_model.stack_ff = 15'($random(seed));
            u_rre_core_model.irq_ff = 8'($random(seed));
            do_op(op, 8'($random(seed)), 1'($random(seed)), 7'($random(seed)), 1'b0);
        end
        $display("test random done");
        test_done();
    end
endmodule
